// ### logic/bwl_config.sv
`timescale 1ns/10ps
`include "bwl_defines.svh"
// How it works
// - wrap settings act only on main array reads, never on register or secure reads.
// - soft reset copies the boot copy into the working copy; hard reset loads the default 70h into both copies.
// - commands 33h, 01h, 65h and 71h read and write this register.
// - command 77h writes only the working copy.
// - bit 7 is reserved and always reads 0.
// - wrap enable touches only the four quad read commands.
// - bits 3:0 hold latency code 0 to 15 for dummy cycles.
// - variable reads wait the programmed latency before data.
// - pattern, protection, protect-register and password reads use one dummy cycle.
// - frequency-dependent reads get 8 dummy cycles for code 0.
// - wrap reads an aligned group and wraps; else sequential without limit.
// - mode-bit cycles come before and outside the latency count.
module bwl_config (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_soft_reset,
	input wire logic i_link_clk,
	input wire logic i_cmd_valid,
	input wire bwl_pkg::bwl_cmd_s i_cmd,
	input wire bwl_pkg::bwl_read_s i_read,
	input wire logic [31:0] i_cur_addr,
	output logic o_cmd_busy,
	output logic [7:0] o_rd_data,
	output logic [4:0] o_dummy_cycles,
	output logic [2:0] o_mode_cycles,
	output logic o_wrap_active,
	output logic [31:0] o_next_addr,
	output logic [7:0] o_working_copy
);
	import bwl_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// core reset: async assert, release through two flops
	logic rst_meta_r, rst_sync_r;
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// link reset, released on the link clock; needs link edges to release
	logic lrst_meta_r, lrst_sync_r;
	always_ff @(posedge i_link_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			lrst_meta_r <= 1'b0;
			lrst_sync_r <= 1'b0;
		end else begin
			lrst_meta_r <= 1'b1;
			lrst_sync_r <= lrst_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link side: command capture and toggle request to the core
	bwl_cmd_s hold_r, hold_nxt;
	logic req_tog_r, req_tog_nxt;
	logic ack_meta_r, ack_sync_r;
	logic core_seen_r;
	logic is_write;

	// only writes need the core; reads are served from the link copy
	always_comb begin
		is_write = (i_cmd.op == `BWL_OP_WRITE_REGISTERS) || (i_cmd.op == `BWL_OP_WRITE_ANY_REG)
			|| (i_cmd.op == `BWL_OP_SET_BURST_SIZE);
		hold_nxt = hold_r;
		req_tog_nxt = req_tog_r;
		// a write while the previous one is still crossing is dropped
		if (i_cmd_valid && is_write && !o_cmd_busy) begin
			hold_nxt = i_cmd;
			req_tog_nxt = ~req_tog_r;
		end
	end

	always_ff @(posedge i_link_clk or negedge lrst_sync_r) begin
		if (!lrst_sync_r) begin
			hold_r <= '0;
			req_tog_r <= 1'b0;
			ack_meta_r <= 1'b0;
			ack_sync_r <= 1'b0;
		end else begin
			hold_r <= hold_nxt;
			req_tog_r <= req_tog_nxt;
			ack_meta_r <= core_seen_r;
			ack_sync_r <= ack_meta_r;
		end
	end

	assign o_cmd_busy = (req_tog_r != ack_sync_r);

	////////////////////////////////////////////////////////////////////////
	// core side: storage of both copies
	logic req_meta_r, req_sync_r, core_seen_nxt;
	logic [7:0] boot_r, boot_nxt, work_r, work_nxt;
	logic [7:0] wval;

	// writes land on one core edge; soft reset reloads the working copy
	always_comb begin
		wval = hold_r.data & `BWL_WR_MASK;
		boot_nxt = boot_r;
		work_nxt = work_r;
		core_seen_nxt = req_sync_r;
		if (req_sync_r != core_seen_r) begin
			unique case (hold_r.op)
				`BWL_OP_WRITE_REGISTERS: begin
					// persistent enable from 06h also updates the boot copy
					work_nxt = wval;
					if (hold_r.boot_wr_en) begin
						boot_nxt = wval;
					end
				end
				`BWL_OP_WRITE_ANY_REG: begin
					if (hold_r.boot_sel) begin
						if (hold_r.boot_wr_en) begin
							boot_nxt = wval;
						end
					end else begin
						work_nxt = wval;
					end
				end
				`BWL_OP_SET_BURST_SIZE: begin
					work_nxt = wval;
				end
				default: begin
					work_nxt = work_r;
				end
			endcase
		end
		if (i_soft_reset) begin
			work_nxt = boot_nxt;
		end
	end

	// boot copy models non-volatile cells with the factory default
	always_ff @(posedge i_core_clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			req_meta_r <= 1'b0;
			req_sync_r <= 1'b0;
			core_seen_r <= 1'b0;
			boot_r <= `BWL_BOOT_DEFAULT;
			work_r <= `BWL_BOOT_DEFAULT;
		end else begin
			req_meta_r <= req_tog_r;
			req_sync_r <= req_meta_r;
			core_seen_r <= core_seen_nxt;
			boot_r <= boot_nxt;
			work_r <= work_nxt;
		end
	end

	assign o_working_copy = work_r;

	////////////////////////////////////////////////////////////////////////
	// core to link publish: words held stable until the link acknowledges
	bwl_pub_e pub_st_r, pub_st_nxt;
	bwl_copies_s pub_r, pub_nxt;
	logic pub_tog_r, pub_tog_nxt;
	logic pack_meta_r, pack_sync_r, link_seen_r;

	always_comb begin
		pub_st_nxt = pub_st_r;
		pub_nxt = pub_r;
		pub_tog_nxt = pub_tog_r;
		unique case (pub_st_r)
			BWL_PUB_IDLE: begin
				if (pub_r.boot != boot_r || pub_r.work != work_r) begin
					pub_nxt = '{boot: boot_r, work: work_r};
					pub_tog_nxt = ~pub_tog_r;
					pub_st_nxt = BWL_PUB_WAIT;
				end
			end
			BWL_PUB_WAIT: begin
				if (pack_sync_r == pub_tog_r) begin
					pub_st_nxt = BWL_PUB_IDLE;
				end
			end
			default: begin
				pub_st_nxt = BWL_PUB_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			pub_st_r <= BWL_PUB_IDLE;
			pub_r <= '{boot: `BWL_BOOT_DEFAULT, work: `BWL_BOOT_DEFAULT};
			pub_tog_r <= 1'b0;
			pack_meta_r <= 1'b0;
			pack_sync_r <= 1'b0;
		end else begin
			pub_st_r <= pub_st_nxt;
			pub_r <= pub_nxt;
			pub_tog_r <= pub_tog_nxt;
			pack_meta_r <= link_seen_r;
			pack_sync_r <= pack_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link side: local copies and read-path outputs
	logic pub_meta_r, pub_sync_r, link_seen_nxt;
	bwl_copies_s lcopy_r, lcopy_nxt;
	logic [7:0] rd_nxt;
	logic [4:0] dummy_nxt;
	logic [2:0] mode_nxt;
	logic wrap_nxt;
	logic [31:0] naddr_nxt;
	logic [3:0] code;
	logic [6:0] grp_mask;

	always_comb begin
		link_seen_nxt = pub_sync_r;
		lcopy_nxt = lcopy_r;
		if (pub_sync_r != link_seen_r) begin
			lcopy_nxt = pub_r;
		end
		code = lcopy_r.work[`BWL_LAT_HI:`BWL_LAT_LO];
		// register reads: 33h shows the working copy, 65h either copy
		rd_nxt = o_rd_data;
		if (i_cmd_valid && i_cmd.op == `BWL_OP_READ_THIRD_CONFIG) begin
			rd_nxt = lcopy_r.work;
		end else if (i_cmd_valid && i_cmd.op == `BWL_OP_READ_ANY_REG) begin
			rd_nxt = i_cmd.boot_sel ? lcopy_r.boot : lcopy_r.work;
		end
		// dummy count for the read being set up
		unique case (i_read.rclass)
			BWL_RC_FIXED: dummy_nxt = 5'h00;
			BWL_RC_SHORT: dummy_nxt = `BWL_DUMMY_SHORT;
			default: dummy_nxt = (code == 4'h0) ? `BWL_DUMMY_CODE0_VAR
				: {1'b0, code};
		endcase
		// mode cycles precede the dummy period and are counted apart
		unique case (i_read.rclass)
			BWL_RC_DUAL_IO: mode_nxt = `BWL_MODE_DUAL_IO;
			BWL_RC_QUAD_IO: mode_nxt = `BWL_MODE_QUAD_IO;
			BWL_RC_DDR_QUAD: mode_nxt = `BWL_MODE_DDR_QUAD;
			default: mode_nxt = 3'h0;
		endcase
		// wrap only on array reads by the four quad commands
		wrap_nxt = i_read.array_read && i_read.wrap_cmd
			&& !lcopy_r.work[`BWL_DIS_BIT];
		// group of 8 << size bytes, aligned; wraps at the boundary
		grp_mask = 7'((8'h08 << lcopy_r.work[`BWL_SIZE_HI:`BWL_SIZE_LO]) - 8'h01);
		if (wrap_nxt) begin
			naddr_nxt = (i_cur_addr & ~{25'h0, grp_mask})
				| ({25'h0, grp_mask} & (i_cur_addr + 32'h1));
		end else begin
			naddr_nxt = i_cur_addr + 32'h1;
		end
	end

	always_ff @(posedge i_link_clk or negedge lrst_sync_r) begin
		if (!lrst_sync_r) begin
			pub_meta_r <= 1'b0;
			pub_sync_r <= 1'b0;
			link_seen_r <= 1'b0;
			lcopy_r <= '{boot: `BWL_BOOT_DEFAULT, work: `BWL_BOOT_DEFAULT};
			o_rd_data <= 8'h00;
			o_dummy_cycles <= 5'h00;
			o_mode_cycles <= 3'h0;
			o_wrap_active <= 1'b0;
			o_next_addr <= 32'h0;
		end else begin
			pub_meta_r <= pub_tog_r;
			pub_sync_r <= pub_meta_r;
			link_seen_r <= link_seen_nxt;
			lcopy_r <= lcopy_nxt;
			o_rd_data <= rd_nxt;
			o_dummy_cycles <= dummy_nxt;
			o_mode_cycles <= mode_nxt;
			o_wrap_active <= wrap_nxt;
			o_next_addr <= naddr_nxt;
		end
	end

endmodule

// ### logic/bwl_defines.svh
`ifndef BWL_DEFINES_SVH
`define BWL_DEFINES_SVH

// command opcodes for this register
`define BWL_OP_READ_THIRD_CONFIG 8'h33
`define BWL_OP_WRITE_REGISTERS 8'h01
`define BWL_OP_READ_ANY_REG 8'h65
`define BWL_OP_WRITE_ANY_REG 8'h71
`define BWL_OP_SET_BURST_SIZE 8'h77

// field positions
`define BWL_RSVD_BIT 7
`define BWL_SIZE_HI 6
`define BWL_SIZE_LO 5
`define BWL_DIS_BIT 4
`define BWL_LAT_HI 3
`define BWL_LAT_LO 0

// boot default: size 11 (64 bytes), wrap disabled, latency code 0
`define BWL_BOOT_DEFAULT 8'h70
// writable bits, reserved bit 7 always zero
`define BWL_WR_MASK 8'h7F

// dummy cycles when the latency code is 0 and for the short class, and per-class mode cycles
`define BWL_DUMMY_CODE0_VAR 5'h08
`define BWL_DUMMY_SHORT 5'h01
`define BWL_MODE_DUAL_IO 3'h4
`define BWL_MODE_QUAD_IO 3'h2
`define BWL_MODE_DDR_QUAD 3'h1

`endif

// ### logic/bwl_pkg.sv
package bwl_pkg;

	// read classes as the command decoder reports them
	typedef enum logic [2:0] {
		BWL_RC_FIXED = 3'h0,
		BWL_RC_SHORT = 3'h1,
		BWL_RC_VAR = 3'h2,
		BWL_RC_DUAL_IO = 3'h3,
		BWL_RC_QUAD_IO = 3'h4,
		BWL_RC_DDR_QUAD = 3'h5
	} bwl_rclass_e;

	// one register command as it leaves the link decoder
	typedef struct packed {
		logic [7:0] op;
		logic [7:0] data;
		logic boot_sel;
		logic boot_wr_en;
	} bwl_cmd_s;

	// read set-up presented by the decoder at the start of a read
	typedef struct packed {
		bwl_rclass_e rclass;
		logic array_read;
		logic wrap_cmd;
	} bwl_read_s;

	// both copies as published to the link side
	typedef struct packed {
		logic [7:0] boot;
		logic [7:0] work;
	} bwl_copies_s;

	typedef enum logic [1:0] {
		BWL_PUB_IDLE = 2'b00,
		BWL_PUB_WAIT = 2'b01
	} bwl_pub_e;

endpackage

// ### tb/bwl_config_chk.sv
`timescale 1ns/10ps
module bwl_config_chk (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_soft_reset,
	input wire logic i_link_clk,
	input wire logic i_cmd_valid,
	input wire bwl_pkg::bwl_cmd_s i_cmd,
	input wire bwl_pkg::bwl_read_s i_read,
	input wire logic [31:0] i_cur_addr,
	input wire logic o_cmd_busy,
	input wire logic [7:0] o_rd_data,
	input wire logic [4:0] o_dummy_cycles,
	input wire logic [2:0] o_mode_cycles,
	input wire logic o_wrap_active,
	input wire logic [31:0] o_next_addr,
	input wire logic [7:0] o_working_copy
);
	import bwl_pkg::*;
	// every check here lives in the link domain
	default clocking @(posedge i_link_clk); endclocking
	default disable iff (!i_resetn);
	rsvd_read_zero_a: assert property (i_cmd_valid && i_cmd.op == 8'h33 |=> !o_rd_data[7])
		else $error("reserved bit read back set");
	short_one_dummy_a: assert property (i_read.rclass == BWL_RC_SHORT |=> o_dummy_cycles == 5'h01)
		else $error("short class dummy count wrong");
	fixed_no_dummy_a: assert property (i_read.rclass == BWL_RC_FIXED |=> o_dummy_cycles == 5'h00)
		else $error("fixed class got dummy cycles");
	var_dummy_range_a: assert property (i_read.rclass == BWL_RC_VAR |=> o_dummy_cycles inside {[1:15]})
		else $error("variable dummy count out of range");
	quad_mode_two_a: assert property (i_read.rclass == BWL_RC_QUAD_IO |=> o_mode_cycles == 3'h2)
		else $error("quad io mode cycles wrong");
	nonarray_no_wrap_a: assert property (!i_read.array_read |=> !o_wrap_active)
		else $error("wrap on a non-array read");
	nonquad_no_wrap_a: assert property (!i_read.wrap_cmd |=> !o_wrap_active)
		else $error("wrap on a non-wrap command");
	seq_next_addr_a: assert property (i_read.rclass != BWL_RC_FIXED && !i_read.wrap_cmd
		|=> o_next_addr == $past(i_cur_addr) + 32'h1)
		else $error("sequential address not incremented");
	wrap_in_group_a: assert property (o_wrap_active |-> o_next_addr[31:6] == $past(i_cur_addr[31:6]))
		else $error("wrapped address left its group");
	write_busy_a: assert property (i_cmd_valid && i_cmd.op == 8'h77 && !o_cmd_busy |=> o_cmd_busy)
		else $error("accepted write did not raise busy");
	busy_bounded_a: assert property ($rose(o_cmd_busy) |-> ##[1:30] !o_cmd_busy)
		else $error("write never completed");
	// main scenarios seen at least once
	cover property (o_wrap_active);
	cover property ($rose(o_cmd_busy));
	cover property (i_read.rclass == BWL_RC_DDR_QUAD && o_mode_cycles == 3'h1);
endmodule
bind bwl_config bwl_config_chk u_chk (.*);

// ### tb/bwl_config_tb.sv
`timescale 1ns/10ps
module bwl_config_tb;
	import bwl_pkg::*;
	logic clk = 1'b0, lclk = 1'b0, rstn = 1'b0, srst = 1'b0, busy, cv, wa;
	bwl_cmd_s cmd;
	bwl_read_s rd = '0;
	logic [31:0] addr = '0, nxt;
	logic [7:0] rdat, work, q;
	logic [4:0] dum;
	logic [2:0] mode;
	int fail_count = 0, tests_run = 0, cyc = 0, mboot = 'h70, mwork = 'h70, r;
	int mtab[6] = '{0, 0, 0, 4, 2, 1};
	// link clock runs unrelated in phase to the core clock
	initial forever #5 clk = ~clk;
	// a 33 MHz link stays below the limit of every latency code
	initial begin
		#3.7;
		forever #15 lclk = ~lclk;
	end
	bwl_config dut (.i_core_clk(clk), .i_resetn(rstn), .i_soft_reset(srst), .i_link_clk(lclk),
		.i_cmd_valid(cv), .i_cmd(cmd), .i_read(rd), .i_cur_addr(addr), .o_cmd_busy(busy),
		.o_rd_data(rdat), .o_dummy_cycles(dum), .o_mode_cycles(mode), .o_wrap_active(wa),
		.o_next_addr(nxt), .o_working_copy(work));
	bwl_host_model host (.i_link_clk(lclk), .i_busy(busy), .i_rd_data(rdat), .o_cmd_valid(cv),
		.o_cmd(cmd));
	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp32(input logic [31:0] g, e);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp8(input logic [7:0] g, e);
		cmp32({24'h0, g}, {24'h0, e});
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// hang guard well above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			conclude();
		end
	end
	// write through the host and mirror it in the model; 77h always goes with bs=0, en=0
	task automatic wr(input logic [7:0] op, d, input logic bs, en);
		if (en) host.send(8'h06, 8'h00, 1'b0, q);
		host.send(op, d, bs, q);
		if (op == 8'h77 || op == 8'h01 || !bs) mwork = d & 'h7F;
		if ((op == 8'h01 || bs) && en) mboot = d & 'h7F;
		cmp8(work, mwork[7:0]);
	endtask
	task automatic rdck(input logic [7:0] op, input logic bs);
		host.send(op, 8'h00, bs, q);
		cmp8(q, bs ? mboot[7:0] : mwork[7:0]);
	endtask
	function automatic int exp_dum(int c);
		if (c == 0) return 0;
		if (c == 1) return 1;
		return (mwork % 16 == 0) ? 8 : mwork % 16;
	endfunction
	task automatic probe(input int c, input logic ar, wc);
		int g, w;
		g = 8 << (mwork / 32 % 4);
		w = ar && wc && (mwork & 16) == 0;
		@(negedge lclk);
		rd = '{bwl_rclass_e'(c), ar, wc};
		addr = $urandom;
		@(negedge lclk);
		cmp32(dum, exp_dum(c));
		cmp32(mode, mtab[c]);
		cmp32(wa, w);
		cmp32(nxt, w ? (addr & ~(g - 1)) | ((addr + 1) & (g - 1)) : addr + 1);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		r = $urandom(32'h7b52280a);
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge lclk);
		cmp8(work, 8'h70);
		rdck(8'h33, 1'b0);
		rdck(8'h65, 1'b1);
		$display("reset values done");
		for (int c = 0; c < 16; c++) begin
			wr(8'h77, {1'b1, 3'($urandom), 4'(c)}, 1'b0, 1'b0);
			for (int k = 0; k < 6; k++) probe(k, 1'b1, 1'b1);
		end
		// a write arriving while busy is dropped, so only the first one lands
		host.burst(8'h25, 8'h3C);
		mwork = 'h25;
		cmp8(work, mwork[7:0]);
		probe(2, 1'b1, 1'b1);
		$display("latency codes done");
		wr(8'h71, 8'h15, 1'b1, 1'b0);
		rdck(8'h65, 1'b1);
		wr(8'h71, 8'hAA, 1'b1, 1'b1);
		rdck(8'h65, 1'b1);
		wr(8'h01, 8'hC3, 1'b0, 1'b0);
		rdck(8'h65, 1'b1);
		wr(8'h71, 8'hDA, 1'b0, 1'b0);
		rdck(8'h65, 1'b0);
		@(negedge clk);
		srst = 1'b1;
		@(negedge clk);
		srst = 1'b0;
		mwork = mboot;
		repeat (12) @(negedge lclk);
		cmp8(work, mwork[7:0]);
		rdck(8'h33, 1'b0);
		wr(8'h01, 8'h4B, 1'b0, 1'b1);
		rdck(8'h65, 1'b1);
		$display("boot copy done");
		for (int s = 0; s < 4; s++) begin
			wr(8'h77, {1'b0, 2'(s), 5'h03}, 1'b0, 1'b0);
			probe(4, 1'b1, 1'b1);
			probe(5, 1'b1, 1'b0);
			probe(2, 1'b0, 1'b1);
		end
		$display("wrap sizes done");
		conclude();
	end
endmodule

// ### tb/bwl_host_model.sv
`timescale 1ns/10ps
module bwl_host_model (
	input wire logic i_link_clk,
	input wire logic i_busy,
	input wire logic [7:0] i_rd_data,
	output logic o_cmd_valid,
	output bwl_pkg::bwl_cmd_s o_cmd
);
	import bwl_pkg::*;
	logic wen_r = 1'b0;
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd = '0;
	end
	// bounded wait for the crossing to finish; link copy trails busy a little
	task automatic idle;
		for (int n = 0; n < 60 && i_busy; n++) @(negedge i_link_clk);
	endtask
	// one command a frame; lines flip after release so stale bits never look valid
	task automatic send(input logic [7:0] op, d, input logic bs, output logic [7:0] q);
		if (op == 8'h06) begin
			wen_r = 1'b1;
			return;
		end
		idle();
		@(negedge i_link_clk);
		o_cmd_valid = 1'b1;
		o_cmd = '{op, d, bs, wen_r};
		@(negedge i_link_clk);
		q = i_rd_data;
		o_cmd_valid = 1'b0;
		o_cmd = ~o_cmd;
		if (op == 8'h01 || op == 8'h71) wen_r = 1'b0;
		idle();
		if (op inside {8'h01, 8'h71, 8'h77}) repeat (8) @(negedge i_link_clk);
	endtask
	// two burst-size writes on back-to-back edges; the second meets busy and is dropped
	task automatic burst(input logic [7:0] d1, d2);
		idle();
		@(negedge i_link_clk);
		o_cmd_valid = 1'b1;
		o_cmd = '{8'h77, d1, 1'b0, 1'b0};
		@(negedge i_link_clk);
		o_cmd = '{8'h77, d2, 1'b0, 1'b0};
		@(negedge i_link_clk);
		o_cmd_valid = 1'b0;
		o_cmd = ~o_cmd;
		idle();
		repeat (8) @(negedge i_link_clk);
	endtask
endmodule
